// ---- pkg/eci_defines.svh ----
// Register offsets, field positions, reset values and widths for the CS extend and idle block
`ifndef ECI_DEFINES_SVH
`define ECI_DEFINES_SVH
// ==========================================
// Register byte addresses
`define ECI_ADDR_W          8
`define ECI_OFS_CSEXT       8'h00
`define ECI_OFS_IDLE        8'h02
`define ECI_OFS_STATUS      8'h04
// ==========================================
// Reset values
`define ECI_CSEXT_RST       16'h0000
`define ECI_IDLE_RST        16'hFF00
// ==========================================
// Field positions
`define ECI_SETUP_LSB       8
`define ECI_HOLD_LSB        0
`define ECI_IDLE_DMA_BIT    15
`define ECI_IDLE_W2R_BIT    14
`define ECI_IDLE_AREA_BIT   13
`define ECI_IDLE_R2W_BIT    12
`define ECI_CNT_B_LSB       10
`define ECI_CNT_A_LSB       8
`define ECI_SEL_LSB         0
// ==========================================
// Widths and counts
`define ECI_AREAS           8
`define ECI_BUS_ADDR_W      24
`define ECI_GAP_W           3
`endif

// ---- pkg/eci_pkg.sv ----
// Types shared by the CS extend and idle block
`default_nettype none
package eci_pkg;
   // ==========================================
   // Sequencer states
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_GAP    = 5'h02,
      ST_SETUP  = 5'h04,
      ST_ACCESS = 5'h08,
      ST_HOLD   = 5'h10
   } eci_state_t;
   // ==========================================
   // Interface kind of the target area
   typedef enum logic [2:0] {
      IF_BASIC  = 3'h0,
      IF_BSRAM  = 3'h1,
      IF_BURST  = 3'h2,
      IF_MUXED  = 3'h3,
      IF_OTHER  = 3'h4
   } eci_if_t;
   // ==========================================
   // One external access request
   typedef struct packed {
      logic [2:0]  area;
      logic        write;
      logic        dmaSingle;
      logic        cpu;
      eci_if_t     ifKind;
      logic [23:0] addr;
   } eci_req_t;
endpackage : eci_pkg
`default_nettype wire

// ---- src/eci_cs_idle.sv ----
// Chip-select and address extension with idle cycle insertion between external bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "eci_defines.svh"
module eci_cs_idle (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        resetn,
   // Register port
   input  wire logic [`ECI_ADDR_W-1:0]      regAddr,
   input  wire logic [15:0]                 regWrData,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [15:0]                 regRdData,
   // Access request side
   input  wire logic                        reqValid,
   input  wire eci_pkg::eci_req_t           reqIn,
   output logic                             reqReady,
   input  wire logic                        accessDone,
   // External bus timing
   output logic      [`ECI_AREAS-1:0]       areaChipSelectN,
   output logic      [`ECI_BUS_ADDR_W-1:0]  busAddr,
   output logic                             idleCycle,
   output logic                             setupCycle,
   output logic                             accessCycle,
   output logic                             holdCycle
);
   import eci_pkg::*;

   // ==========================================
   // Reset release
   logic [1:0] rstSync_q;
   logic       rstn;
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rstSync_q <= 2'h0;
      else
         rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rstn = rstSync_q[1];

   // ==========================================
   // Idle count decode
   function automatic logic [2:0] cntA(input logic [1:0] code);
      cntA = {1'b0, code} + 3'h1;
   endfunction : cntA

   function automatic logic [2:0] cntB(input logic [1:0] code);
      cntB = (code == 2'h0) ? 3'h0 : {1'b0, code} + 3'h1;
   endfunction : cntB

   function automatic logic extKind(input eci_if_t k);
      extKind = (k == IF_BASIC) || (k == IF_BSRAM) || (k == IF_BURST) || (k == IF_MUXED);
   endfunction : extKind

   // ==========================================
   // Registers
   logic [15:0] csExt_q, csExt_d, idleCtl_q, idleCtl_d, rdData_q, rdData_d;
   logic [15:0] statusWord;
   eci_state_t  state_q, state_d;
   logic [2:0]  lastArea_q, lastArea_d;
   logic        lastValid_q, lastValid_d, lastWrite_q, lastWrite_d, lastDma_q, lastDma_d;

   always_comb
   begin
      csExt_d   = csExt_q;
      idleCtl_d = idleCtl_q;
      rdData_d  = 16'h0000;
      if (regWr && regAddr == `ECI_OFS_CSEXT)
         csExt_d = regWrData;
      else if (regWr && regAddr == `ECI_OFS_IDLE)
         idleCtl_d = regWrData;
      if (regRd && regAddr == `ECI_OFS_CSEXT)
         rdData_d = csExt_q;
      else if (regRd && regAddr == `ECI_OFS_IDLE)
         rdData_d = idleCtl_q;
      else if (regRd && regAddr == `ECI_OFS_STATUS)
         rdData_d = statusWord;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         csExt_q   <= `ECI_CSEXT_RST;
         idleCtl_q <= `ECI_IDLE_RST;
         rdData_q  <= 16'h0000;
      end
      else
      begin
         csExt_q   <= csExt_d;
         idleCtl_q <= idleCtl_d;
         rdData_q  <= rdData_d;
      end
   end
   assign regRdData  = rdData_q;
   assign statusWord = {5'h00, lastValid_q, lastWrite_q, lastDma_q, lastArea_q, state_q};

   // ==========================================
   // Idle need for the pending request
   logic       condDma, condW2R, condArea, condR2W, useB;
   logic [2:0] needA, needAB, idleNeed;
   always_comb
   begin
      condDma  = idleCtl_q[`ECI_IDLE_DMA_BIT] && lastValid_q && lastDma_q;
      condW2R  = idleCtl_q[`ECI_IDLE_W2R_BIT] && lastValid_q && lastWrite_q && !reqIn.write;
      condArea = idleCtl_q[`ECI_IDLE_AREA_BIT] && lastValid_q && !lastWrite_q
                 && !reqIn.write && (lastArea_q != reqIn.area);
      condR2W  = idleCtl_q[`ECI_IDLE_R2W_BIT] && lastValid_q && !lastWrite_q && reqIn.write;
      useB     = idleCtl_q[`ECI_SEL_LSB + reqIn.area];
      needA    = cntA(idleCtl_q[`ECI_CNT_A_LSB +: 2]);
      // count B only for two conditions
      needAB   = useB ? cntB(idleCtl_q[`ECI_CNT_B_LSB +: 2]) : needA;
      idleNeed = 3'h0;
      if (condArea || condR2W)
         idleNeed = needAB;
      if ((condDma || condW2R) && needA > idleNeed)
         idleNeed = needA;
   end

   // ==========================================
   // Sequencer
   eci_req_t   cur_q, cur_d;
   logic [2:0] gap_q, gap_d;
   logic       setupNeed, holdNeed;
   always_comb
   begin
      setupNeed = csExt_q[`ECI_SETUP_LSB + cur_q.area] && extKind(cur_q.ifKind);
      // hold extension, burst processor reads excluded
      holdNeed  = csExt_q[`ECI_HOLD_LSB + cur_q.area] && extKind(cur_q.ifKind)
                  && !(cur_q.ifKind == IF_BURST && cur_q.cpu && !cur_q.write);
   end

   always_comb
   begin
      state_d     = state_q;
      cur_d       = cur_q;
      gap_d       = gap_q;
      lastValid_d = lastValid_q;
      lastWrite_d = lastWrite_q;
      lastDma_d   = lastDma_q;
      lastArea_d  = lastArea_q;
      case (state_q)
         ST_IDLE:
         begin
            if (reqValid)
            begin
               cur_d = reqIn;
               if (idleNeed != 3'h0)
               begin
                  state_d = ST_GAP;
                  gap_d   = idleNeed - 3'h1;
               end
               else if (csExt_q[`ECI_SETUP_LSB + reqIn.area] && extKind(reqIn.ifKind))
                  state_d = ST_SETUP;
               else
                  state_d = ST_ACCESS;
            end
            else
               lastValid_d = 1'b0;
         end
         ST_GAP:
         begin
            if (gap_q != 3'h0)
               gap_d = gap_q - 3'h1;
            else if (setupNeed)
               state_d = ST_SETUP;
            else
               state_d = ST_ACCESS;
         end
         ST_SETUP:
            state_d = ST_ACCESS;
         ST_ACCESS:
         begin
            if (accessDone)
            begin
               lastValid_d = 1'b1;
               lastWrite_d = cur_q.write;
               lastDma_d   = cur_q.dmaSingle && cur_q.write;
               lastArea_d  = cur_q.area;
               state_d     = holdNeed ? ST_HOLD : ST_IDLE;
            end
         end
         ST_HOLD:
            state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q     <= ST_IDLE;
         cur_q       <= '0;
         gap_q       <= 3'h0;
         lastValid_q <= 1'b0;
         lastWrite_q <= 1'b0;
         lastDma_q   <= 1'b0;
         lastArea_q  <= 3'h0;
      end
      else
      begin
         state_q     <= state_d;
         cur_q       <= cur_d;
         gap_q       <= gap_d;
         lastValid_q <= lastValid_d;
         lastWrite_q <= lastWrite_d;
         lastDma_q   <= lastDma_d;
         lastArea_q  <= lastArea_d;
      end
   end

   // ==========================================
   // Bus outputs
   logic [7:0]  csN_q, csN_d;
   logic [23:0] addr_q, addr_d;
   logic [4:0]  ph_q, ph_d;
   always_comb
   begin
      csN_d  = 8'hFF;
      addr_d = addr_q;
      ph_d   = {state_d == ST_IDLE, state_d == ST_GAP, state_d == ST_SETUP,
                state_d == ST_ACCESS, state_d == ST_HOLD};
      if (state_d == ST_SETUP || state_d == ST_ACCESS || state_d == ST_HOLD)
      begin
         csN_d[cur_d.area] = 1'b0;
         addr_d            = cur_d.addr;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         csN_q  <= 8'hFF;
         addr_q <= 24'h000000;
         ph_q   <= 5'h10;
      end
      else
      begin
         csN_q  <= csN_d;
         addr_q <= addr_d;
         ph_q   <= ph_d;
      end
   end
   assign areaChipSelectN = csN_q;
   assign busAddr         = addr_q;
   assign reqReady        = ph_q[4];
   assign idleCycle       = ph_q[3];
   assign setupCycle      = ph_q[2];
   assign accessCycle     = ph_q[1];
   assign holdCycle       = ph_q[0];

   // ==========================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence seqSetupAccess;
      setupCycle ##1 accessCycle;
   endsequence

   chk_setup_order: assert property (
      (state_q == ST_IDLE && reqValid && idleNeed == 3'h0
       && csExt_q[`ECI_SETUP_LSB + reqIn.area] && extKind(reqIn.ifKind)) |=> seqSetupAccess)
      else $error("setup cycle not followed by access");
   chk_setup_cause: assert property (
      (state_q == ST_SETUP) |-> csExt_q[`ECI_SETUP_LSB + cur_q.area])
      else $error("setup cycle without setup bit");
   chk_hold_after: assert property (
      (state_q == ST_ACCESS && accessDone && holdNeed) |=> holdCycle ##1 reqReady)
      else $error("hold cycle missing after access");
   chk_ext_kind: assert property (
      (state_q == ST_SETUP || state_q == ST_HOLD) |-> extKind(cur_q.ifKind))
      else $error("extension on unsupported interface");
   chk_burst_hold: assert property (
      holdCycle |-> !(cur_q.ifKind == IF_BURST && cur_q.cpu && !cur_q.write))
      else $error("hold cycle on burst processor read");
   chk_dma_gap: assert property (
      (state_q == ST_IDLE && reqValid && condDma) |=> idleCycle)
      else $error("no idle after DMA write");
   chk_gap_off: assert property (
      (state_q == ST_IDLE && reqValid && idleCtl_q[15:12] == 4'h0) |=> (state_q != ST_GAP))
      else $error("idle cycle with all conditions off");
   chk_count_a: assert property (
      (state_q == ST_IDLE && reqValid && condW2R && !condR2W && !condArea
       && idleCtl_q[9:8] == 2'h0) |=> (state_q == ST_GAP) ##1 (state_q != ST_GAP))
      else $error("count A 00 not one idle cycle");
   chk_b_zero: assert property (
      (state_q == ST_IDLE && reqValid && condR2W && !condDma && useB
       && idleCtl_q[11:10] == 2'h0) |=> (state_q != ST_GAP))
      else $error("count B 00 inserted idle");
endmodule : eci_cs_idle
`default_nettype wire

// ---- verification/eci_ext_mem_model.sv ----
// External memory stand-in that ends each access promptly or after wait cycles
`timescale 1ns/1ps
`default_nettype none
module eci_ext_mem_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // Access phase
   input  wire logic       accessCycle,
   input  wire logic [2:0] slowCycles,
   output logic            accessDone
);
   logic [2:0] waitCnt_q;
   // ==========================================
   // Wait counter, restarts with each access
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         waitCnt_q <= 3'h0;
      else if (accessDone || !accessCycle)
         waitCnt_q <= 3'h0;
      else
         waitCnt_q <= waitCnt_q + 3'h1;
   end
   assign accessDone = accessCycle && (waitCnt_q == slowCycles);
endmodule : eci_ext_mem_model
`default_nettype wire

// ---- verification/test_eci_cs_idle.sv ----
// Testbench for the CS extend and idle block
`timescale 1ns/1ps
`default_nettype none
module test_eci_cs_idle;
   import eci_pkg::*;
   logic core_clk, resetn, regWr, regRd, reqValid, reqReady, accessDone;
   logic idleCycle, setupCycle, accessCycle, holdCycle;
   logic [7:0] regAddr, areaChipSelectN;
   logic [15:0] regWrData, regRdData;
   logic [23:0] busAddr;
   logic [2:0] slowCycles;
   eci_req_t reqIn, w0, w1, d0, r0, r1;
   int errors, samples_checked;
   eci_cs_idle i_dut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .reqValid(reqValid), .reqIn(reqIn), .reqReady(reqReady), .accessDone(accessDone),
      .areaChipSelectN(areaChipSelectN), .busAddr(busAddr), .idleCycle(idleCycle),
      .setupCycle(setupCycle), .accessCycle(accessCycle), .holdCycle(holdCycle));
   eci_ext_mem_model i_mem (.core_clk(core_clk), .resetn(resetn),
      .accessCycle(accessCycle), .slowCycles(slowCycles), .accessDone(accessDone));
   // ==========================================
   // Shared tasks
   function automatic eci_req_t mk(input logic [2:0] a, input logic w, d, c, input eci_if_t f);
      mk = '{area: a, write: w, dmaSingle: d, cpu: c, ifKind: f, addr: {a, 21'h1A5C3}};
   endfunction : mk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic hang();
      errors++;
      $display("mismatch ready wait expected 1 seen timeout");
      tally_and_finish();
   endtask : hang
   task automatic check(input string what, input logic [23:0] exp, got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
   endtask : regWrite
   task automatic regRead(input logic [7:0] a, input logic [15:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(negedge core_clk);
      check("register read", {8'h0, e}, {8'h0, regRdData});
      @(posedge core_clk);
      @(negedge core_clk);
      check("read data cleared", 24'h0, {8'h0, regRdData});
      @(posedge core_clk);
   endtask : regRead
   // Expected shape per access: idle count times 4, plus 2 for setup, plus 1 for hold
   task automatic runSeq(input eci_req_t rq[$], input logic [23:0] ex[$]);
      int n;
      logic [23:0] ph;
      logic [23:0] acc;
      reqIn <= rq[0];
      reqValid <= 1'b1;
      for (n = 0; n < 60; n++)
      begin
         @(posedge core_clk);
         if (reqReady === 1'b1) break;
      end
      if (reqReady !== 1'b1) hang();
      foreach (rq[k])
      begin
         if (k + 1 < rq.size()) reqIn <= rq[k + 1];
         else reqValid <= 1'b0;
         ph = 24'h0;
         acc = 24'h0;
         for (n = 0; n < 60; n++)
         begin
            @(posedge core_clk);
            if (reqReady === 1'b1) break;
            if (accessCycle === 1'b1) acc = acc + 24'h1;
            ph = ph + (idleCycle ? 24'h4 : setupCycle ? 24'h2 : holdCycle ? 24'h1 : 24'h0);
            if (!idleCycle) check("chip select", {16'h0, ~(8'h01 << rq[k].area)},
               {16'h0, areaChipSelectN});
            if (!idleCycle) check("bus address", rq[k].addr, busAddr);
         end
         if (reqReady !== 1'b1) hang();
         check("chip select idle", 24'hFF, {16'h0, areaChipSelectN});
         check("cycle shape", ex[k], ph);
         check("access length", {21'h0, slowCycles} + 24'h1, acc);
      end
   endtask : runSeq
   // ==========================================
   // Scenarios
   task automatic scnRegs();
      regRead(8'h00, 16'h0000);
      regRead(8'h02, 16'hFF00);
      regRead(8'h04, 16'h0001);
      regWrite(8'h06, 16'hFFFF);
      regRead(8'h06, 16'h0000);
      regWrite(8'h00, 16'hF00F);
      regRead(8'h00, 16'hF00F);
   endtask : scnRegs
   task automatic scnExtend();
      eci_req_t rq[$];
      logic [23:0] ex[$];
      slowCycles <= 3'h2;
      regWrite(8'h02, 16'h0000);
      for (int k = 0; k < 8; k++)
      begin
         rq.push_back(mk(k[2:0], 1'b1, 1'b0, 1'b1, eci_if_t'(k % 5)));
         ex.push_back((k % 5 == 4) ? 24'h0 : (k >= 4) ? 24'h2 : 24'h1);
      end
      rq.push_back(mk(3'h1, 1'b0, 1'b0, 1'b1, IF_BURST));
      ex.push_back(24'h0);
      rq.push_back(mk(3'h1, 1'b0, 1'b0, 1'b0, IF_BURST));
      ex.push_back(24'h1);
      runSeq(rq, ex);
   endtask : scnExtend
   task automatic scnIdle();
      logic [23:0] g;
      slowCycles <= 3'h0;
      regWrite(8'h00, 16'h0000);
      for (int c = 0; c < 4; c++)
         for (int a = 0; a < 4; a++)
         begin
            g = 24'((a + 1) * 4);
            regWrite(8'h02, 16'((16'h1000 << c) | (a << 8)));
            runSeq('{r0, w0}, '{24'h0, (c == 0) ? g : 24'h0});
            runSeq('{r0, r1}, '{24'h0, (c == 1) ? g : 24'h0});
            runSeq('{w0, r0}, '{24'h0, (c == 2) ? g : 24'h0});
            runSeq('{d0, w0}, '{24'h0, (c == 3) ? g : 24'h0});
         end
   endtask : scnIdle
   task automatic scnCountB();
      logic [23:0] g;
      for (int b = 0; b < 4; b++)
      begin
         g = (b == 0) ? 24'h0 : 24'((b + 1) * 4);
         regWrite(8'h02, 16'h7002 | 16'(b << 10));
         runSeq('{r0, r1}, '{24'h0, g});
         runSeq('{r0, w1}, '{24'h0, g});
         runSeq('{r0, w0}, '{24'h0, 24'h4});
         runSeq('{w1, r1}, '{24'h0, 24'h4});
      end
   endtask : scnCountB
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial
   begin
      errors = 0;
      samples_checked = 0;
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      reqValid = 1'b0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      reqIn = '0;
      slowCycles = 3'h0;
      w0 = mk(3'h0, 1'b1, 1'b0, 1'b1, IF_BASIC);
      w1 = mk(3'h1, 1'b1, 1'b0, 1'b1, IF_BASIC);
      d0 = mk(3'h0, 1'b1, 1'b1, 1'b0, IF_BASIC);
      r0 = mk(3'h0, 1'b0, 1'b0, 1'b1, IF_BASIC);
      r1 = mk(3'h1, 1'b0, 1'b0, 1'b1, IF_BASIC);
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      scnRegs();
      scnExtend();
      scnIdle();
      scnCountB();
      tally_and_finish();
   end
endmodule : test_eci_cs_idle
`default_nettype wire
